// >>> verilog/asp_core.sv
/*
 * Digital side of a two-channel 12-bit sampling converter: serial
 * control/result port, power and track/hold control, result FIFO and
 * an AXI4-Lite register slave.
 * Assumes pins arrive asynchronously and the serial clock is far
 * slower than clock_i (at least eight clock_i cycles per phase).
 */
`timescale 1ns/1ps
`include "asp_defines.svh"

module asp_core (
	input  wire logic                clock_i,
	input  wire logic                reset_n_i,
	input  wire asp_pkg::asp_addr_t  s_axi_awaddr_i,
	input  wire logic                s_axi_awvalid_i,
	output logic                     s_axi_awready_o,
	input  wire logic [31:0]         s_axi_wdata_i,
	input  wire logic [3:0]          s_axi_wstrb_i,
	input  wire logic                s_axi_wvalid_i,
	output logic                     s_axi_wready_o,
	output logic [1:0]               s_axi_bresp_o,
	output logic                     s_axi_bvalid_o,
	input  wire logic                s_axi_bready_i,
	input  wire asp_pkg::asp_addr_t  s_axi_araddr_i,
	input  wire logic                s_axi_arvalid_i,
	output logic                     s_axi_arready_o,
	output logic [31:0]              s_axi_rdata_o,
	output logic [1:0]               s_axi_rresp_o,
	output logic                     s_axi_rvalid_o,
	input  wire logic                s_axi_rready_i,
	input  wire logic                select_n_i,
	input  wire logic                serial_clock_i,
	input  wire logic                serial_in_i,
	output logic                     serial_out_o,
	output logic                     serial_out_oe_o,
	input  wire asp_pkg::asp_sample_t sample_data_i,
	input  wire logic                sample_valid_i,
	output logic                     sample_ready_o,
	output logic                     convert_start_o,
	output logic                     powered_o,
	output logic                     track_o,
	output logic                     pin_b_is_input_o,
	output logic                     pick_input_b_o,
	output logic                     internal_ref_en_o
);
	import asp_pkg::*;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	logic [2:0]  pin_meta_q;
	logic [2:0]  pin_sync_q;
	logic        sclk_last_q;
	logic        sel_last_q;
	logic        sel_n_s;
	logic        sclk_s;
	logic        din_s;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        frame_start;
	logic        frame_end;
	asp_state_t  state_q;
	asp_state_t  state_d;
	logic [3:0]  rise_cnt_q;
	logic [3:0]  fall_cnt_q;
	asp_ctrl_t   ctrl_shift_q;
	asp_ctrl_t   ctrl_q;
	asp_ctrl_t   ctrl_next;
	logic        ctrl_load;
	logic        ctrl_take;
	asp_word_t   out_shift_q;
	asp_sample_t next_sample;
	asp_pmode_t  pmode;
	logic        powered_d;
	logic        powered_q;
	logic        pick_q;
	logic        start_q;
	logic        underrun_q;
	logic        fifo_valid;
	asp_sample_t fifo_data;
	logic [3:0]  fifo_level;
	logic        enable_q;
	logic        flush_q;
	logic [31:0] frames_q;

	// two-flop synchronisers; order {data in, serial clock, select}
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			pin_meta_q  <= 3'h1;
			pin_sync_q  <= 3'h1;
			sclk_last_q <= 1'b0;
			sel_last_q  <= 1'b1;
		end else begin
			pin_meta_q  <= {serial_in_i, serial_clock_i, select_n_i};
			pin_sync_q  <= pin_meta_q;
			sclk_last_q <= pin_sync_q[1];
			sel_last_q  <= pin_sync_q[0];
		end
	end

	assign sel_n_s     = pin_sync_q[0];
	assign sclk_s      = pin_sync_q[1];
	assign din_s       = pin_sync_q[2];
	assign sclk_rise   = sclk_s && !sclk_last_q;
	assign sclk_fall   = !sclk_s && sclk_last_q;
	// a disabled port ignores new frames; one under way still drives the line until select goes high
	assign frame_start = sel_last_q && !sel_n_s && enable_q;
	assign frame_end   = !sel_last_q && sel_n_s;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ASP_IDLE: begin
				if (frame_start) begin
					state_d = ASP_SHIFT;
				end
			end
			ASP_SHIFT: begin
				if (frame_end) begin
					state_d = ASP_IDLE;
				end else if (sclk_fall && fall_cnt_q == `ASP_LAST_FALL) begin
					state_d = ASP_DONE;
				end
			end
			ASP_DONE: begin
				if (frame_end) begin
					state_d = ASP_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_q <= ASP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// control capture: only the first eight rising edges of a frame
	assign ctrl_take = sclk_rise && state_q != ASP_IDLE
		&& rise_cnt_q != `ASP_CTRL_DONE;
	assign ctrl_load = ctrl_take && rise_cnt_q == `ASP_LAST_CTRL;
	assign ctrl_next = {ctrl_shift_q[6:0], din_s};

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			rise_cnt_q   <= 4'h0;
			ctrl_shift_q <= `ASP_CTRL_RESET;
			ctrl_q       <= `ASP_CTRL_RESET;
		end else if (frame_start) begin
			rise_cnt_q <= 4'h0;
		end else if (ctrl_take) begin
			rise_cnt_q   <= 4'(rise_cnt_q + 1'b1);
			ctrl_shift_q <= ctrl_next;
			if (ctrl_load) begin
				ctrl_q <= ctrl_next;
			end
		end
	end

	// result word: a missing sample goes out as zero, flagged
	assign next_sample = fifo_valid ? fifo_data : '0;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			fall_cnt_q  <= 4'h0;
			out_shift_q <= '0;
		end else if (frame_start) begin
			fall_cnt_q  <= 4'h0;
			out_shift_q <= {`ASP_LEAD_ZEROS, next_sample};
		end else if (sclk_fall && state_q == ASP_SHIFT) begin
			fall_cnt_q  <= 4'(fall_cnt_q + 1'b1);
			out_shift_q <= {out_shift_q[14:0], 1'b0};
		end
	end

	// about three clock_i cycles from pin edge to line change
	assign serial_out_o    = out_shift_q[`ASP_WORD_BITS-1];
	assign serial_out_oe_o = (state_q != ASP_IDLE);

	// power: code 3 is undefined and is treated like code 0
	assign pmode = ctrl_q[`ASP_CB_PM_HI:`ASP_CB_PM_LO];
	assign powered_d = (pmode == `ASP_PM_ALWAYS) ? 1'b1
		: (pmode == `ASP_PM_AUTO) ? (state_d == ASP_SHIFT)
		: (state_d != ASP_IDLE);

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			powered_q <= 1'b0;
			pick_q    <= 1'b0;
			start_q   <= 1'b0;
		end else begin
			powered_q <= powered_d;
			start_q   <= frame_start;
			if (frame_start) begin
				pick_q <= ctrl_q[`ASP_CB_DUAL] && ctrl_q[`ASP_CB_CHAN];
			end
		end
	end

	assign convert_start_o   = start_q;
	assign powered_o         = powered_q;
	assign track_o           = (state_q != ASP_SHIFT);
	assign pin_b_is_input_o  = ctrl_q[`ASP_CB_DUAL];
	assign pick_input_b_o    = pick_q;
	assign internal_ref_en_o = !ctrl_q[`ASP_CB_REF];

	asp_fifo #(
		.WIDTH (`ASP_DATA_BITS),
		.DEPTH (`ASP_FIFO_DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.reset_n_i   (reset_n_i),
		.flush_i     (flush_q),
		.in_valid_i  (sample_valid_i),
		.in_data_i   (sample_data_i),
		.in_ready_o  (sample_ready_o),
		.out_valid_o (fifo_valid),
		.out_data_o  (fifo_data),
		.out_ready_i (frame_start),
		.level_o     (fifo_level)
	);

	// AXI4-Lite slave
	logic        aw_hold_q;
	asp_addr_t   awaddr_q;
	logic        w_hold_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        do_write;
	logic        do_read;
	logic        wr_config;
	logic        wr_status;
	logic        clr_underrun;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	function automatic logic reg_mapped(input asp_addr_t a);
		reg_mapped = (a == `ASP_OFF_CONTROL) || (a == `ASP_OFF_CONFIG)
			|| (a == `ASP_OFF_STATUS) || (a == `ASP_OFF_FRAMES);
	endfunction

	assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
	assign s_axi_wready_o  = !w_hold_q && !bvalid_q;
	assign s_axi_arready_o = !rvalid_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;

	assign do_write     = aw_hold_q && w_hold_q && !bvalid_q;
	assign do_read      = s_axi_arvalid_i && !rvalid_q;
	assign wr_config    = do_write && awaddr_q == `ASP_OFF_CONFIG
		&& wstrb_q[0];
	assign wr_status    = do_write && awaddr_q == `ASP_OFF_STATUS
		&& wstrb_q[0];
	assign clr_underrun = wr_status && wdata_q[`ASP_ST_UNDERRUN];

	assign status_word = {20'h0, fifo_level, 4'h0, underrun_q, powered_q,
		state_q == ASP_SHIFT, state_q != ASP_IDLE};
	assign rd_word =
		(s_axi_araddr_i == `ASP_OFF_CONTROL) ? {24'h0, ctrl_q}
		: (s_axi_araddr_i == `ASP_OFF_CONFIG) ? {31'h0, enable_q}
		: (s_axi_araddr_i == `ASP_OFF_STATUS) ? status_word
		: (s_axi_araddr_i == `ASP_OFF_FRAMES) ? frames_q
		: 32'h0;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= '0;
			w_hold_q  <= 1'b0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `ASP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata_i;
				wstrb_q  <= s_axi_wstrb_i;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= reg_mapped(awaddr_q) ? `ASP_RESP_OKAY
					: `ASP_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= `ASP_RESP_OKAY;
		end else if (do_read) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= reg_mapped(s_axi_araddr_i) ? `ASP_RESP_OKAY
				: `ASP_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

	// underrun set wins over a clear in the same cycle
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			enable_q   <= `ASP_CFG_RESET;
			flush_q    <= 1'b0;
			underrun_q <= 1'b0;
			frames_q   <= 32'h0;
		end else begin
			flush_q <= wr_config && wdata_q[`ASP_CFG_FLUSH];
			if (wr_config) begin
				enable_q <= wdata_q[`ASP_CFG_ENABLE];
			end
			if (frame_start && !fifo_valid) begin
				underrun_q <= 1'b1;
			end else if (clr_underrun) begin
				underrun_q <= 1'b0;
			end
			if (frame_start) begin
				frames_q <= 32'(frames_q + 1'b1);
			end
		end
	end

	a_start_pulse: assert property (
		frame_start |=> convert_start_o ##1 !convert_start_o)
		else $error("conversion start not a one-cycle pulse");
	a_follow_power: assert property (
		$past(pmode) == `ASP_PM_FOLLOW |-> powered_o == (state_q != ASP_IDLE))
		else $error("power does not follow select");
	a_ctrl_load: assert property (
		ctrl_load |=> ctrl_q == $past(ctrl_next))
		else $error("control word not loaded");
	a_ctrl_only_eight: assert property (
		!ctrl_load |=> $stable(ctrl_q))
		else $error("control changed outside eighth bit");
	a_zero_single: assert property (
		ctrl_q == `ASP_CTRL_RESET && frame_start
		|=> !pick_input_b_o && !pin_b_is_input_o && internal_ref_en_o)
		else $error("all-zero control not single channel");
	a_dout_on_fall: assert property (
		state_q == ASP_SHIFT && $past(state_q) == ASP_SHIFT
		&& $changed(serial_out_o) |-> $past(sclk_fall))
		else $error("output changed without falling edge");
	a_lead_zeros: assert property (
		state_q == ASP_SHIFT && fall_cnt_q < `ASP_ZERO_FALLS |-> !serial_out_o)
		else $error("leading zeros missing");
	a_word_load: assert property (
		frame_start |=> out_shift_q[`ASP_DATA_BITS-1:0] == $past(next_sample))
		else $error("result word not loaded");
	a_track_end: assert property (
		state_q == ASP_SHIFT && sclk_fall && fall_cnt_q == `ASP_LAST_FALL
		&& !frame_end |=> track_o && state_q == ASP_DONE)
		else $error("sampler not back to track");
	a_auto_off: assert property (
		$past(pmode) == `ASP_PM_AUTO && state_q == ASP_DONE |-> !powered_o)
		else $error("auto power-down missed");
	a_chan_pick: assert property (
		frame_start |=> pick_input_b_o
		== $past(ctrl_q[`ASP_CB_DUAL] && ctrl_q[`ASP_CB_CHAN]))
		else $error("wrong input picked");
	a_oe_release: assert property (
		frame_end |=> !serial_out_oe_o)
		else $error("output still driven after select high");
	a_bresp_hold: assert property (
		bvalid_q && !s_axi_bready_i |=> bvalid_q && $stable(bresp_q))
		else $error("write response dropped");

	c_full_frame: cover property (state_q == ASP_DONE ##[1:200] frame_end);
	c_ctrl_load: cover property (ctrl_load);
	c_underrun: cover property (frame_start && !fifo_valid);
	c_write: cover property (do_write ##1 bvalid_q);
endmodule

// >>> verilog/asp_defines.svh
/*
 * Offsets, field positions, reset values and counts of the serial
 * converter port. Included by the package and by asp_core; asp_fifo does not include it.
 */
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

`define ASP_ADDR_W       8
`define ASP_OFF_CONTROL  8'h00
`define ASP_OFF_CONFIG   8'h04
`define ASP_OFF_STATUS   8'h08
`define ASP_OFF_FRAMES   8'h0C

`define ASP_CFG_ENABLE   0
`define ASP_CFG_FLUSH    1
`define ASP_CFG_RESET    1'b1
`define ASP_ST_UNDERRUN  3

`define ASP_CTRL_BITS    8
`define ASP_CTRL_RESET   8'h00
`define ASP_CB_REF       5
`define ASP_CB_DUAL      4
`define ASP_CB_CHAN      3
`define ASP_CB_PM_HI     1
`define ASP_CB_PM_LO     0

`define ASP_PM_FOLLOW    2'h0
`define ASP_PM_ALWAYS    2'h1
`define ASP_PM_AUTO      2'h2

`define ASP_DATA_BITS    12
`define ASP_WORD_BITS    16
`define ASP_LEAD_ZEROS   4'h0
`define ASP_LAST_CTRL    4'h7
`define ASP_CTRL_DONE    4'h8
`define ASP_LAST_FALL    4'hF
`define ASP_ZERO_FALLS   4'h4
`define ASP_FIFO_DEPTH   8

`define ASP_RESP_OKAY    2'h0
`define ASP_RESP_SLVERR  2'h2

`endif

// >>> verilog/asp_pkg.sv
/*
 * Types of the serial converter port.
 * Assumes asp_defines.svh is on the include path.
 */
`include "asp_defines.svh"

package asp_pkg;
	typedef logic [`ASP_DATA_BITS-1:0] asp_sample_t;
	typedef logic [`ASP_CTRL_BITS-1:0] asp_ctrl_t;
	typedef logic [`ASP_WORD_BITS-1:0] asp_word_t;
	typedef logic [`ASP_ADDR_W-1:0]    asp_addr_t;
	typedef logic [1:0]                asp_pmode_t;
	typedef enum logic [1:0] {
		ASP_IDLE,
		ASP_SHIFT,
		ASP_DONE
	} asp_state_t;
endpackage

// >>> verilog/asp_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module asp_fifo #(
	parameter int unsigned WIDTH = 12,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic                         clock_i,
	input  wire logic                         reset_n_i,
	input  wire logic                         flush_i,
	input  wire logic                         in_valid_i,
	input  wire logic [WIDTH-1:0]             in_data_i,
	output logic                              in_ready_o,
	output logic                              out_valid_o,
	output logic [WIDTH-1:0]                  out_data_o,
	input  wire logic                         out_ready_i,
	output logic [$clog2(DEPTH+1)-1:0]        level_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic             push;
	logic             pop;

	// wraps for any depth, not only powers of two
	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready_o  = (cnt_q != CW'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];
	assign level_o     = cnt_q;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i || flush_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= next_ptr(wr_q);
			end
			if (pop) begin
				rd_q <= next_ptr(rd_q);
			end
			if (push && !pop) begin
				cnt_q <= CW'(cnt_q + 1'b1);
			end else if (pop && !push) begin
				cnt_q <= CW'(cnt_q - 1'b1);
			end
		end
	end
endmodule

// >>> bench/asp_host_model.sv
/*
 * Host serial controller model: frames transfers, shifts control
 * bits in, collects the result word and watches the output pin.
 * Assumes clock_i is the bench clock and the device syncs its pins.
 */
`timescale 1ns/1ps

module asp_host_model #(
	parameter int HALF = 10
) (
	input  wire logic clock_i,
	input  wire logic serial_out_i,
	input  wire logic serial_out_oe_i,
	input  wire logic powered_i,
	input  wire logic track_i,
	output logic      select_n_o,
	output logic      serial_clock_o,
	output logic      serial_in_o
);
	logic tie_low = 1'b0;
	logic end_pwr;
	logic end_track;
	logic mid_track;
	logic mid_oe;
	logic line;
	logic out_q = 1'b0;
	int   edge_faults = 0;
	int   oe_faults = 0;
	int   idle_n = 0;

	// a released line reads as the inverse, so a missing drive shows up
	assign line = serial_out_oe_i ? serial_out_i : ~serial_out_i;

	initial begin
		select_n_o = 1'b1;
		serial_clock_o = 1'b0;
		serial_in_o = 1'b0;
	end

	// result may only move while our clock is low
	always @(posedge clock_i) begin
		if (!select_n_o && serial_clock_o && serial_out_i !== out_q)
			edge_faults <= edge_faults + 1;
		// allow the pin synchroniser a few cycles
		if (idle_n > 5 && serial_out_oe_i !== 1'b0)
			oe_faults <= oe_faults + 1;
		idle_n <= select_n_o ? idle_n + 1 : 0;
		out_q <= serial_out_i;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// clock stands low outside frames
	task automatic frame(input logic [7:0] ctrl, input int nclk,
		output logic [15:0] word);
		word = 16'h0000;
		@(posedge clock_i);
		select_n_o <= 1'b0;
		wait_cyc(HALF);
		for (int i = 0; i < nclk; i++) begin
			// control bits first, MSB first
			if (tie_low)
				serial_in_o <= 1'b0;
			else
				serial_in_o <= (i < 8) ? ctrl[7 - i] : ~serial_in_o;
			wait_cyc(HALF);
			serial_clock_o <= 1'b1;
			word = {word[14:0], line};
			if (i == 7) begin
				mid_track = track_i;
				mid_oe = serial_out_oe_i;
			end
			wait_cyc(HALF);
			serial_clock_o <= 1'b0;
		end
		wait_cyc(HALF);
		end_pwr = powered_i;
		end_track = track_i;
		select_n_o <= 1'b1;
		// no stale level between frames unless tied low
		serial_in_o <= tie_low ? 1'b0 : ~serial_in_o;
		wait_cyc(2 * HALF);
	endtask
endmodule

// >>> bench/adc_serial_port_conversion_bench.sv
/*
 * Self-checking bench of the serial converter port: register bus,
 * result buffer and framed serial transfers through a host model.
 * Assumes asp_pkg, asp_core and asp_host_model are compiled first.
 */
`timescale 1ns/1ps

module adc_serial_port_conversion_bench;
	import asp_pkg::*;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	asp_addr_t   awaddr = 8'h00;
	asp_addr_t   araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, svalid = 1'b0;
	asp_sample_t sdata = 12'h000;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic        sready, sout, soe, start, pwr, trk, pinb, pickb, refen;
	logic        sel_n, sclk, sin;
	logic [15:0] word;
	logic [7:0]  prev;
	int          failures = 0;
	int          cmp_count = 0;
	int          starts = 0;
	logic [7:0]  rc [8] = '{8'h00, 8'h19, 8'h32, 8'h80,
		8'h39, 8'h11, 8'h0A, 8'h03};
	asp_sample_t rs [8] = '{12'hA5C, 12'h3F0, 12'hFFF, 12'h001,
		12'h800, 12'h7FF, 12'h555, 12'h123};

	always #12.5 clk = ~clk;
	always @(posedge clk) if (start === 1'b1) starts <= starts + 1;

	asp_core asp_core_inst (
		.clock_i(clk), .reset_n_i(rst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .select_n_i(sel_n),
		.serial_clock_i(sclk), .serial_in_i(sin),
		.serial_out_o(sout), .serial_out_oe_o(soe),
		.sample_data_i(sdata), .sample_valid_i(svalid),
		.sample_ready_o(sready), .convert_start_o(start),
		.powered_o(pwr), .track_o(trk), .pin_b_is_input_o(pinb),
		.pick_input_b_o(pickb), .internal_ref_en_o(refen)
	);

	asp_host_model #(.HALF(10)) host_inst (
		.clock_i(clk), .serial_out_i(sout), .serial_out_oe_i(soe),
		.powered_i(pwr), .track_i(trk), .select_n_o(sel_n),
		.serial_clock_o(sclk), .serial_in_o(sin)
	);

	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic guard(input int n);
		if (n > 200) begin
			failures++;
			$display("BAD handshake expected answer seen none");
			wrap_up();
		end
	endtask

	// ready looked at mid-cycle, so the taking edge is known exactly
	task automatic axi_wr(input asp_addr_t a, input logic [31:0] d);
		logic pa, pw, ta, tw;
		int   n;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ta = pa && awready;
			tw = pw && wready;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
			n++;
			guard(n);
		end
		do begin
			@(negedge clk);
			n++;
			guard(n);
		end while (bvalid !== 1'b1);
		resp = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input asp_addr_t a);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			n++;
			guard(n);
		end while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
			n++;
			guard(n);
		end while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	task automatic push(input asp_sample_t s);
		int n;
		n = 0;
		@(posedge clk);
		sdata <= s;
		svalid <= 1'b1;
		do begin
			@(negedge clk);
			n++;
			guard(n);
		end while (sready !== 1'b1);
		@(posedge clk);
		svalid <= 1'b0;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("oe", 0, soe);
		chk("track", 1, trk);
		chk("powered", 0, pwr);
		axi_rd(8'h00);
		chk("control", 0, rd);
		axi_rd(8'h04);
		chk("config", 1, rd);
		for (int i = 0; i < 8; i++)
			push(rs[i]);
		@(negedge clk);
		chk("buffer full", 0, sready);
		axi_rd(8'h08);
		chk("level", 8, rd[11:8]);
		// first row runs with the input pin tied low
		host_inst.tie_low = 1'b1;
		for (int i = 0; i < 8; i++) begin
			prev = (i == 0) ? 8'h00 : rc[i - 1];
			host_inst.frame(rc[i], 16, word);
			host_inst.tie_low = 1'b0;
			chk("word", {4'h0, rs[i]}, word);
			chk("pwr end", rc[i][1:0] != 2'h2, host_inst.end_pwr);
			chk("pwr idle", rc[i][1:0] == 2'h1, pwr);
			chk("track", 2'b01, {host_inst.mid_track, host_inst.end_track});
			chk("pin b", rc[i][4], pinb);
			chk("pick", prev[4] & prev[3], pickb);
			chk("ref", !rc[i][5], refen);
			chk("oe frame", 1, host_inst.mid_oe);
			axi_rd(8'h00);
			chk("control", rc[i], rd);
		end
		chk("starts", 8, starts);
		axi_rd(8'h0C);
		chk("frames", 8, rd);
		chk("edges", 0, host_inst.edge_faults);
		chk("oe idle", 0, host_inst.oe_faults);
		// empty buffer gives a zero word and a sticky flag
		host_inst.frame(8'h01, 16, word);
		chk("empty word", 0, word);
		axi_rd(8'h08);
		chk("underrun", 1, rd[3]);
		axi_wr(8'h08, 32'h0000_0008);
		axi_rd(8'h08);
		chk("underrun clr", 0, rd[3]);
		host_inst.frame(8'h12, 5, word);
		axi_rd(8'h00);
		chk("abort ctrl", 8'h01, rd);
		axi_wr(8'h04, 32'h0000_0000);
		host_inst.frame(8'h11, 16, word);
		chk("off word", 16'hFFFF, word);
		chk("starts off", 10, starts);
		axi_wr(8'h04, 32'h0000_0001);
		axi_wr(8'h00, 32'h0000_00FF);
		chk("ro resp", 0, resp);
		axi_rd(8'h00);
		chk("ro keep", 8'h01, rd);
		axi_wr(8'h10, 32'h0000_0001);
		chk("bad wr", 2, resp);
		axi_rd(8'h10);
		chk("bad rd", 2, resp);
		chk("bad data", 0, rd);
		// flush empties the buffer and leaves the port enabled
		push(12'h0AB);
		axi_rd(8'h08);
		chk("one level", 1, rd[11:8]);
		axi_wr(8'h04, 32'h0000_0003);
		axi_rd(8'h08);
		chk("flush", 0, rd[11:8]);
		axi_rd(8'h04);
		chk("flush cfg", 1, rd);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		axi_rd(8'h00);
		chk("ctrl reset", 0, rd);
		wrap_up();
	end
endmodule
